// ===== core/wtc_params.svh
/*
 * Constants of the winder tension and torque block: offsets, bits,
 * reset values and scale figures.
 * Assumes percentages are held in units of 0.01 %, so 100.00 % is 10000.
 */
`ifndef WTC_PARAMS_SVH
`define WTC_PARAMS_SVH

// register byte offsets, word aligned
`define WTC_OFS_CTRL        8'h00
`define WTC_OFS_TENS_REF    8'h04
`define WTC_OFS_TAPER       8'h08
`define WTC_OFS_TENS_TRIM   8'h0C
`define WTC_OFS_MIN_DIA     8'h10
`define WTC_OFS_TORQ_TRIM   8'h14
`define WTC_OFS_STIC_COMP   8'h18
`define WTC_OFS_STIC_THR    8'h1C
`define WTC_OFS_STAT_FRIC   8'h20
`define WTC_OFS_DYN_FRIC    8'h24
`define WTC_OFS_FIX_INER    8'h28
`define WTC_OFS_VAR_INER    8'h2C
`define WTC_OFS_MAT_WIDTH   8'h30
`define WTC_OFS_ACC_SCALE   8'h34
`define WTC_OFS_ACC_EXT     8'h38
`define WTC_OFS_TAPERED     8'h40
`define WTC_OFS_TOTAL       8'h44
`define WTC_OFS_TORQUE      8'h48
`define WTC_OFS_ACC_VAL     8'h4C
`define WTC_OFS_INERTIA     8'h50

// control register bits
`define WTC_CTRL_HYPER      0
`define WTC_CTRL_OVERWIND   1
`define WTC_CTRL_W          2

// scale figures in 0.01 % units
`define WTC_FULL_SCALE      64'sh0000_0000_0000_2710
`define WTC_REEL_STILL      64'sh0000_0000_0000_00C8
`define WTC_ACCEL_DIV       64'sh0000_0000_0000_0064

// reset values and default update divider
`define WTC_RST_CTRL        2'h2
`define WTC_RST_MAT_WIDTH   16'h2710
`define WTC_RST_STIC_THR    16'h01F4
`define WTC_UPDATE_DIV      100

`endif

// ===== core/wtc_pkg.sv
/*
 * Shared types of the winder tension and torque compensation block.
 * Assumes no other package; users reference every name as wtc_pkg::name.
 */
package wtc_pkg;

   // wide intermediate before saturation
   typedef logic signed [63:0] wtc_wide_t;

   // taper profile chosen by the hyperbolic enable bit
   typedef enum logic {
      WTC_LINEAR,
      WTC_HYPERBOLIC
   } wtc_taper_t;

endpackage : wtc_pkg

// ===== core/wtc_core.sv
/*
 * Winder tension and torque compensation datapath with Avalon-MM slave.
 * Forms tension, friction and inertia terms and a
 * torque demand for one current clamp. Assumes diameter and speed
 * inputs come from logic on clk_sys_i, in signed 0.01 % units.
 */
// Our own choices: the Avalon-MM slave port and the address map.
// Functional notes
// - linear taper: ref/100 times (100 - (dia-min) times strength/100)
// - hyperbolic taper: strength product over present diameter
// - strength +100 % drops tension progressively to zero at full diameter
// - zero strength keeps tapered tension equal to the reference
// - strength -100 % raises tension to twice reference at full diameter
// - one enable bit selects hyperbolic or linear profile
// - torque demand sums scaled tension and all active compensation terms
// - stiction only while web speed above threshold and reel below 2 %
// - stiction threshold unsigned, compared with web speed magnitude
// - static friction adds a constant at every speed
// - dynamic friction is its setting times web speed
// - fixed inertia gain goes as 1/diameter, unity at minimum diameter
// - variable inertia gain goes as (diameter - minimum) cubed, zero to unity
// - material width scales variable inertia, 100 % is reference material
// - internal acceleration differentiates line speed, times scaler
// - zero scaler takes external acceleration, else reports calculated
// - torque demand routed to positive or negative current clamp
// - inertia compensation carries the sign of acceleration
// - tension trim added to tapered tension gives total tension
`include "wtc_params.svh"

module wtc_core #(
   parameter int DW         = 16,
   parameter int UPDATE_DIV = `WTC_UPDATE_DIV
) (
   input  wire logic          clk_sys_i,
   input  wire logic          rst_n_i,
   input  wire logic [7:0]    address_i,
   input  wire logic          read_i,
   input  wire logic          write_i,
   input  wire logic [31:0]   writedata_i,
   input  wire logic [3:0]    byteenable_i,
   output logic [31:0]        readdata_o,
   output logic               waitrequest_o,
   input  wire logic [DW-1:0] diameter_i,
   input  wire logic [DW-1:0] web_speed_i,
   input  wire logic [DW-1:0] reel_speed_i,
   input  wire logic [DW-1:0] accel_speed_i,
   output logic [DW-1:0]      tapered_tension_o,
   output logic [DW-1:0]      total_tension_o,
   output logic [DW-1:0]      torque_demand_o,
   output logic [DW-1:0]      pos_clamp_o,
   output logic [DW-1:0]      neg_clamp_o,
   output logic [DW-1:0]      acceleration_value_o
);

   localparam int DIVW = $clog2(UPDATE_DIV + 1);

   // three-operand products must fit 64 bits
   initial begin
      if (DW < 16 || DW > 20)
         $error("DW must lie in 16..20");
      if (UPDATE_DIV < 1)
         $error("UPDATE_DIV below 1");
   end

   typedef logic signed [DW-1:0] wtc_val_t;

   typedef struct packed {
      logic [`WTC_CTRL_W-1:0] ctrl;
      wtc_val_t               tens_ref;
      wtc_val_t               taper;
      wtc_val_t               tens_trim;
      wtc_val_t               min_dia;
      wtc_val_t               torq_trim;
      wtc_val_t               stic_comp;
      logic [DW-1:0]          stic_thr;
      wtc_val_t               stat_fric;
      wtc_val_t               dyn_fric;
      wtc_val_t               fix_iner;
      wtc_val_t               var_iner;
      wtc_val_t               mat_width;
      wtc_val_t               acc_scale;
      wtc_val_t               acc_ext;
      wtc_val_t               speed_prev;
      wtc_val_t               tapered;
      wtc_val_t               total;
      wtc_val_t               torque;
      wtc_val_t               pos_clamp;
      wtc_val_t               neg_clamp;
      wtc_val_t               accel;
      wtc_val_t               inertia;
      logic [DIVW-1:0]        div_cnt;
      logic [31:0]            rdata;
      logic                   wait_n;
   } wtc_state_t;

   wtc_state_t state_reg;
   wtc_state_t state_next;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic wtc_val_t sat(input wtc_pkg::wtc_wide_t v);
      wtc_pkg::wtc_wide_t hi;
      wtc_pkg::wtc_wide_t lo;
      hi = (64'sd1 <<< (DW - 1)) - 64'sd1;
      lo = -(64'sd1 <<< (DW - 1));
      if (v > hi)
         sat = wtc_val_t'(hi);
      else if (v < lo)
         sat = wtc_val_t'(lo);
      else
         sat = wtc_val_t'(v);
   endfunction

   function automatic wtc_pkg::wtc_wide_t wide(input wtc_val_t v);
      wide = wtc_pkg::wtc_wide_t'(v);
   endfunction

   function automatic wtc_pkg::wtc_wide_t mag(input wtc_val_t v);
      mag = (v < 0) ? -wide(v) : wide(v);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i])
            merge[8*i +: 8] = wd[8*i +: 8];
      end
   endfunction

   function automatic logic [31:0] rd_word(input logic [DW-1:0] v);
      rd_word = {{(32 - DW){1'b0}}, v};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      wtc_pkg::wtc_wide_t s;
      wtc_pkg::wtc_wide_t dia;
      wtc_pkg::wtc_wide_t span;
      wtc_pkg::wtc_wide_t den;
      wtc_pkg::wtc_wide_t tt;
      wtc_pkg::wtc_wide_t tot;
      wtc_pkg::wtc_wide_t gfix;
      wtc_pkg::wtc_wide_t gx;
      wtc_pkg::wtc_wide_t gvar;
      wtc_pkg::wtc_wide_t iner;
      wtc_pkg::wtc_wide_t stic;
      wtc_pkg::wtc_wide_t thr;
      wtc_pkg::wtc_wide_t dyn;
      wtc_pkg::wtc_wide_t tq;
      wtc_val_t           tapered_v;
      wtc_val_t           total_v;
      wtc_val_t           accel_v;
      wtc_val_t           torque_v;
      wtc_pkg::wtc_taper_t mode;
      logic               tick;
      logic               req;
      logic [31:0]        wmerge;
      state_next = state_reg;
      s          = `WTC_FULL_SCALE;
      dia        = wide(diameter_i);
      span       = dia - wide(state_reg.min_dia);
      mode       = state_reg.ctrl[`WTC_CTRL_HYPER] ? wtc_pkg::WTC_HYPERBOLIC
                                                   : wtc_pkg::WTC_LINEAR;

      // update pulse
      tick = (state_reg.div_cnt == DIVW'(UPDATE_DIV - 1));
      state_next.div_cnt = tick ? '0 : state_reg.div_cnt + DIVW'(1);

      // taper denominator
      case (mode)
         wtc_pkg::WTC_LINEAR:     den = s;
         wtc_pkg::WTC_HYPERBOLIC: den = (dia > 0) ? dia : 64'sd1;
         default:                 den = s;
      endcase
      // +/-100 % strength: 0 or 200 % at full span
      tt        = wide(state_reg.tens_ref) * (s - span * wide(state_reg.taper) / den) / s;
      tapered_v = sat(tt);
      tot       = wide(tapered_v) + wide(state_reg.tens_trim);
      total_v   = sat(tot);

      // acceleration source
      if (state_reg.acc_scale == '0)
         accel_v = state_reg.acc_ext;
      else
         accel_v = sat((wide(accel_speed_i) - wide(state_reg.speed_prev))
                       * wide(state_reg.acc_scale) / `WTC_ACCEL_DIV);

      // fixed mass gain min/dia
      gfix = (dia > 0) ? wide(state_reg.min_dia) * s / dia : s;
      // variable mass gain: span cubed
      gx = (s - wide(state_reg.min_dia) > 0) ? span * s / (s - wide(state_reg.min_dia))
                                             : 64'sd0;
      if (gx < 0)
         gx = 64'sd0;
      else if (gx > s)
         gx = s;
      gvar = gx * gx / s * gx / s;
      // signed accel keeps deceleration compensation negative
      iner = wide(accel_v) * (wide(state_reg.fix_iner) * gfix / s
             + wide(state_reg.var_iner) * gvar / s * wide(state_reg.mat_width) / s)
             / s;

      // friction
      thr  = $signed({{(64 - DW){1'b0}}, state_reg.stic_thr});
      stic = (mag(web_speed_i) > thr && mag(reel_speed_i) < `WTC_REEL_STILL)
             ? wide(state_reg.stic_comp) : 64'sd0;
      dyn  = wide(state_reg.dyn_fric) * wide(web_speed_i) / s;

      // torque: tension times diameter plus terms
      tq = wide(total_v) * dia / s + stic + wide(state_reg.stat_fric) + dyn
           + wide(sat(iner)) + wide(state_reg.torq_trim);
      torque_v = sat(tq);

      if (tick) begin
         state_next.tapered    = tapered_v;
         state_next.total      = total_v;
         state_next.accel      = accel_v;
         state_next.inertia    = sat(iner);
         state_next.torque     = torque_v;
         state_next.speed_prev = wtc_val_t'(accel_speed_i);
         // overwind: positive clamp; underwind: negative
         if (state_reg.ctrl[`WTC_CTRL_OVERWIND]) begin
            state_next.pos_clamp = torque_v;
            state_next.neg_clamp = '0;
         end else begin
            state_next.pos_clamp = '0;
            state_next.neg_clamp = sat(-wide(torque_v));
         end
      end

      // bus: one wait cycle, answer and write on the same edge
      req    = (read_i | write_i) & state_reg.wait_n;
      wmerge = 32'h0000_0000;
      state_next.wait_n = ~req;
      state_next.rdata  = 32'h0000_0000;
      if (req && read_i) begin
         case (address_i)
            `WTC_OFS_CTRL:      state_next.rdata = {30'h0000_0000, state_reg.ctrl};
            `WTC_OFS_TENS_REF:  state_next.rdata = rd_word(state_reg.tens_ref);
            `WTC_OFS_TAPER:     state_next.rdata = rd_word(state_reg.taper);
            `WTC_OFS_TENS_TRIM: state_next.rdata = rd_word(state_reg.tens_trim);
            `WTC_OFS_MIN_DIA:   state_next.rdata = rd_word(state_reg.min_dia);
            `WTC_OFS_TORQ_TRIM: state_next.rdata = rd_word(state_reg.torq_trim);
            `WTC_OFS_STIC_COMP: state_next.rdata = rd_word(state_reg.stic_comp);
            `WTC_OFS_STIC_THR:  state_next.rdata = rd_word(state_reg.stic_thr);
            `WTC_OFS_STAT_FRIC: state_next.rdata = rd_word(state_reg.stat_fric);
            `WTC_OFS_DYN_FRIC:  state_next.rdata = rd_word(state_reg.dyn_fric);
            `WTC_OFS_FIX_INER:  state_next.rdata = rd_word(state_reg.fix_iner);
            `WTC_OFS_VAR_INER:  state_next.rdata = rd_word(state_reg.var_iner);
            `WTC_OFS_MAT_WIDTH: state_next.rdata = rd_word(state_reg.mat_width);
            `WTC_OFS_ACC_SCALE: state_next.rdata = rd_word(state_reg.acc_scale);
            `WTC_OFS_ACC_EXT:   state_next.rdata = rd_word(state_reg.acc_ext);
            `WTC_OFS_TAPERED:   state_next.rdata = rd_word(state_reg.tapered);
            `WTC_OFS_TOTAL:     state_next.rdata = rd_word(state_reg.total);
            `WTC_OFS_TORQUE:    state_next.rdata = rd_word(state_reg.torque);
            `WTC_OFS_ACC_VAL:   state_next.rdata = rd_word(state_reg.accel);
            `WTC_OFS_INERTIA:   state_next.rdata = rd_word(state_reg.inertia);
            default:            state_next.rdata = 32'h0000_0000;
         endcase
      end
      if (req && write_i) begin
         case (address_i)
            `WTC_OFS_CTRL: begin
               wmerge = merge({30'h0000_0000, state_reg.ctrl}, writedata_i, byteenable_i);
               state_next.ctrl = wmerge[`WTC_CTRL_W-1:0];
            end
            `WTC_OFS_TENS_REF: begin
               wmerge = merge(rd_word(state_reg.tens_ref), writedata_i, byteenable_i);
               state_next.tens_ref = wmerge[DW-1:0];
            end
            `WTC_OFS_TAPER: begin
               wmerge = merge(rd_word(state_reg.taper), writedata_i, byteenable_i);
               state_next.taper = wmerge[DW-1:0];
            end
            `WTC_OFS_TENS_TRIM: begin
               wmerge = merge(rd_word(state_reg.tens_trim), writedata_i, byteenable_i);
               state_next.tens_trim = wmerge[DW-1:0];
            end
            `WTC_OFS_MIN_DIA: begin
               wmerge = merge(rd_word(state_reg.min_dia), writedata_i, byteenable_i);
               state_next.min_dia = wmerge[DW-1:0];
            end
            `WTC_OFS_TORQ_TRIM: begin
               wmerge = merge(rd_word(state_reg.torq_trim), writedata_i, byteenable_i);
               state_next.torq_trim = wmerge[DW-1:0];
            end
            `WTC_OFS_STIC_COMP: begin
               wmerge = merge(rd_word(state_reg.stic_comp), writedata_i, byteenable_i);
               state_next.stic_comp = wmerge[DW-1:0];
            end
            `WTC_OFS_STIC_THR: begin
               wmerge = merge(rd_word(state_reg.stic_thr), writedata_i, byteenable_i);
               state_next.stic_thr = wmerge[DW-1:0];
            end
            `WTC_OFS_STAT_FRIC: begin
               wmerge = merge(rd_word(state_reg.stat_fric), writedata_i, byteenable_i);
               state_next.stat_fric = wmerge[DW-1:0];
            end
            `WTC_OFS_DYN_FRIC: begin
               wmerge = merge(rd_word(state_reg.dyn_fric), writedata_i, byteenable_i);
               state_next.dyn_fric = wmerge[DW-1:0];
            end
            `WTC_OFS_FIX_INER: begin
               wmerge = merge(rd_word(state_reg.fix_iner), writedata_i, byteenable_i);
               state_next.fix_iner = wmerge[DW-1:0];
            end
            `WTC_OFS_VAR_INER: begin
               wmerge = merge(rd_word(state_reg.var_iner), writedata_i, byteenable_i);
               state_next.var_iner = wmerge[DW-1:0];
            end
            `WTC_OFS_MAT_WIDTH: begin
               wmerge = merge(rd_word(state_reg.mat_width), writedata_i, byteenable_i);
               state_next.mat_width = wmerge[DW-1:0];
            end
            `WTC_OFS_ACC_SCALE: begin
               wmerge = merge(rd_word(state_reg.acc_scale), writedata_i, byteenable_i);
               state_next.acc_scale = wmerge[DW-1:0];
            end
            `WTC_OFS_ACC_EXT: begin
               wmerge = merge(rd_word(state_reg.acc_ext), writedata_i, byteenable_i);
               state_next.acc_ext = wmerge[DW-1:0];
            end
            default: wmerge = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         state_reg           <= '0;
         state_reg.ctrl      <= `WTC_RST_CTRL;
         state_reg.mat_width <= wtc_val_t'(`WTC_RST_MAT_WIDTH);
         state_reg.stic_thr  <= DW'(`WTC_RST_STIC_THR);
         state_reg.wait_n    <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign readdata_o           = state_reg.rdata;
   assign waitrequest_o        = state_reg.wait_n;
   assign tapered_tension_o    = state_reg.tapered;
   assign total_tension_o      = state_reg.total;
   assign torque_demand_o      = state_reg.torque;
   assign pos_clamp_o          = state_reg.pos_clamp;
   assign neg_clamp_o          = state_reg.neg_clamp;
   assign acceleration_value_o = state_reg.accel;

endmodule // wtc_core

// ===== verification/wtc_core_checker.sv
/* Checker on wtc_core ports: bus handshake, clamp routing, output hold.
   Assumes UPDATE_DIV of 3 or more. */
module wtc_core_checker #(
   parameter int DW         = 16,
   parameter int UPDATE_DIV = 100
) (
   input wire logic          clk_sys_i,
   input wire logic          rst_n_i,
   input wire logic          read_i,
   input wire logic          write_i,
   input wire logic [31:0]   readdata_o,
   input wire logic          waitrequest_o,
   input wire logic [DW-1:0] tapered_tension_o,
   input wire logic [DW-1:0] total_tension_o,
   input wire logic [DW-1:0] torque_demand_o,
   input wire logic [DW-1:0] pos_clamp_o,
   input wire logic [DW-1:0] neg_clamp_o,
   input wire logic [DW-1:0] acceleration_value_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   wait_answer_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
      else $error("no answer");
   wait_pulse_a: assert property (!waitrequest_o |=> waitrequest_o)
      else $error("answer too long");
   wait_cause_a: assert property ($fell(waitrequest_o) |-> $past(read_i || write_i))
      else $error("stray answer");
   rdata_idle_a: assert property (waitrequest_o |-> readdata_o == '0)
      else $error("stray read data");
   rdata_upper_a: assert property (readdata_o[31:DW] == '0)
      else $error("upper bits set");
   clamp_pos_a: assert property (pos_clamp_o != '0 |->
      pos_clamp_o == torque_demand_o && neg_clamp_o == '0) else $error("bad pos clamp");
   clamp_neg_a: assert property (neg_clamp_o != '0 |->
      DW'(neg_clamp_o + torque_demand_o) == '0 && pos_clamp_o == '0) else $error("bad neg clamp");
   clamp_route_a: assert property (torque_demand_o != '0 |->
      pos_clamp_o == torque_demand_o || neg_clamp_o != '0) else $error("no clamp");
   torque_hold_a: assert property ($changed(torque_demand_o) |=>
      $stable(torque_demand_o) [*2]) else $error("torque moved");
   tension_hold_a: assert property ($changed(total_tension_o) ||
      $changed(tapered_tension_o) |=>
      ($stable(total_tension_o) && $stable(tapered_tension_o)) [*2]) else $error("tension moved");
   accel_hold_a: assert property ($changed(acceleration_value_o) |=>
      $stable(acceleration_value_o) [*2]) else $error("accel moved");
endmodule // wtc_core_checker

bind wtc_core wtc_core_checker #(.DW(DW), .UPDATE_DIV(UPDATE_DIV)) i_wtc_core_checker (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .read_i(read_i), .write_i(write_i),
   .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
   .tapered_tension_o(tapered_tension_o), .total_tension_o(total_tension_o),
   .torque_demand_o(torque_demand_o), .pos_clamp_o(pos_clamp_o),
   .neg_clamp_o(neg_clamp_o), .acceleration_value_o(acceleration_value_o)
);

// ===== verification/wtc_line_model.sv
/* Far side model: diameter, web and reel speed, ramping line speed.
   Assumes the bench sets targets. */
module wtc_line_model (
   input  wire logic        clk_sys_i,
   input  wire logic        rst_n_i,
   input  wire logic [15:0] dia_set_i,
   input  wire logic [15:0] web_set_i,
   input  wire logic [15:0] reel_set_i,
   input  wire logic [15:0] step_i,
   output logic [15:0]      diameter_o,
   output logic [15:0]      web_speed_o,
   output logic [15:0]      reel_speed_o,
   output logic [15:0]      line_speed_o
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         {diameter_o, web_speed_o, reel_speed_o, line_speed_o} <= '0;
      end else begin
         diameter_o <= dia_set_i;
         web_speed_o <= web_set_i;
         reel_speed_o <= reel_set_i;
         // small step keeps accel near 1 %
         line_speed_o <= line_speed_o + step_i;
      end
   end
endmodule // wtc_line_model

// ===== verification/tb_winder_tension_torque_comp.sv
/* Self-checking bench for wtc_core with an integer datapath model.
   Assumes 1 tick latency. */
module tb_winder_tension_torque_comp;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int     UD = 4;
   localparam longint S  = 10000;
   logic        clk_sys = 1'b0;
   logic        rst_n   = 1'b0;
   logic [7:0]  addr    = 8'h00;
   logic        rd      = 1'b0;
   logic        wr      = 1'b0;
   logic [31:0] wdat    = 32'h0000_0000;
   logic [3:0]  be      = 4'hF;
   logic [15:0] dia_s   = 16'h0000;
   logic [15:0] web_s   = 16'h0000;
   logic [15:0] reel_s  = 16'h0000;
   logic [15:0] step_s  = 16'h0000;
   logic [31:0] rdat, q, seed = 32'hA2630E0B;
   logic        wreq;
   logic [15:0] dia, web, reel, lspd, tap_o, tot_o, trq_o, pos_o, neg_o, acc_o;
   longint      rv[16];
   int          bad_count = 0;
   int          n_tests = 0;

   always #5 clk_sys = ~clk_sys;

   wtc_core #(.DW(16), .UPDATE_DIV(UD)) i_wtc_core (
      .clk_sys_i(clk_sys), .rst_n_i(rst_n), .address_i(addr), .read_i(rd), .write_i(wr),
      .writedata_i(wdat), .byteenable_i(be), .readdata_o(rdat), .waitrequest_o(wreq),
      .diameter_i(dia), .web_speed_i(web), .reel_speed_i(reel), .accel_speed_i(lspd),
      .tapered_tension_o(tap_o), .total_tension_o(tot_o), .torque_demand_o(trq_o),
      .pos_clamp_o(pos_o), .neg_clamp_o(neg_o), .acceleration_value_o(acc_o));
   wtc_line_model i_wtc_line_model (
      .clk_sys_i(clk_sys), .rst_n_i(rst_n), .dia_set_i(dia_s), .web_set_i(web_s),
      .reel_set_i(reel_s), .step_i(step_s), .diameter_o(dia), .web_speed_o(web),
      .reel_speed_o(reel), .line_speed_o(lspd));

   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input logic [15:0] got, input longint e);
      n_tests++;
      if (got !== 16'(e)) begin
         bad_count++;
         $display("[ERR] %0t output %h expected %h", $time, got, 16'(e));
      end
   endtask
   // hold request until waitrequest samples low; watchdog ends a hang
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      do @(posedge clk_sys); while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wr_reg(input logic [7:0] a, input longint v);
      rv[a[7:2]] = v;
      bus(1'b1, a, 32'(v));
   endtask
   task automatic rd_chk(input logic [7:0] a, input longint e);
      bus(1'b0, a, 32'h0000_0000);
      chk_reg(q, {16'h0000, 16'(e)});
   endtask
   function automatic longint rnd(input longint lo, input longint span);
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return lo + longint'(seed % 32'(span));
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   function automatic longint sat(input longint v);
      return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
   endfunction
   function automatic longint taper_m(input longint d);
      longint den;
      den = rv[0][0] ? (d <= 0 ? 1 : d) : S;
      return sat(rv[1] * (S - (d - rv[4]) * rv[2] / den) / S);
   endfunction
   function automatic longint iner_m(input longint a, input longint d);
      longint gf, x, gv;
      gf = d <= 0 ? S : rv[4] * S / d;
      x = (S - rv[4] <= 0) ? 0 : (d - rv[4]) * S / (S - rv[4]);
      x = x < 0 ? 0 : (x > S ? S : x);
      gv = x * x / S * x / S;
      return sat(a * (rv[10] * gf / S + rv[11] * gv / S * rv[12] / S) / S);
   endfunction
   function automatic longint torq_m(input longint a, input longint d, input longint w,
                                     input longint r);
      longint st;
      st = ((w < 0 ? -w : w) > rv[7] && (r < 0 ? -r : r) < 200) ? rv[6] : 0;
      return sat(sat(taper_m(d) + rv[3]) * d / S + st + rv[8] + rv[9] * w / S
                 + iner_m(a, d) + rv[5]);
   endfunction
   task automatic setin(input longint d, input longint w, input longint r);
      dia_s <= 16'(d);
      web_s <= 16'(w);
      reel_s <= 16'(r);
   endtask
   task automatic check_outs(input longint a);
      longint d, t;
      repeat (4 * UD) @(posedge clk_sys);
      d = longint'($signed(dia_s));
      t = torq_m(a, d, longint'($signed(web_s)), longint'($signed(reel_s)));
      chk_out(tap_o, taper_m(d));
      chk_out(tot_o, sat(taper_m(d) + rv[3]));
      chk_out(trq_o, t);
      chk_out(pos_o, rv[0][1] ? t : 0);
      chk_out(neg_o, rv[0][1] ? 0 : sat(-t));
      chk_out(acc_o, a);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      longint tl[3] = '{10000, 0, -10000};
      longint ws[5] = '{600, -600, 600, 400, -600};
      longint rs[5] = '{100, 100, 300, 100, -100};
      longint v;
      rv[0] = 2;
      rv[7] = 500;
      rv[12] = 10000;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 15; i++) rd_chk(8'(i * 4), rv[i]);
      for (int i = 1; i < 15; i++) begin
         v = rnd(-32768, 65536);
         wr_reg(8'(i * 4), v);
         rd_chk(8'(i * 4), v);
         wr_reg(8'(i * 4), 0);
      end
      be <= 4'h1;
      bus(1'b1, 8'h0C, 32'h0000_5A5A);
      be <= 4'hF;
      rv[3] = 90;
      rd_chk(8'h0C, rv[3]);
      rd_chk(8'h3C, 0);
      rd_chk(8'h54, 0);
      rd_chk(8'h06, 0);
      $display("register test done");
      wr_reg(8'h04, 5000);
      setin(S, 0, 0);
      for (int h = 0; h < 2; h++)
         for (int j = 0; j < 3; j++) begin
            wr_reg(8'h00, 2 + h);
            wr_reg(8'h08, tl[j]);
            check_outs(0);
            chk_out(tap_o, 5000 - 5000 * tl[j] / S);
         end
      wr_reg(8'h10, 1000);
      wr_reg(8'h04, 7000);
      wr_reg(8'h08, -4000);
      setin(5000, 0, 0);
      wr_reg(8'h00, 2);
      check_outs(0);
      chk_out(tap_o, 8120);
      wr_reg(8'h00, 3);
      check_outs(0);
      chk_out(tap_o, 9240);
      for (int i = 0; i < 6; i++) begin
         wr_reg(8'h00, 2 + rnd(0, 2));
         wr_reg(8'h08, rnd(-10000, 20001));
         wr_reg(8'h04, rnd(0, 10001));
         wr_reg(8'h0C, rnd(-500, 1000));
         setin(rnd(1000, 9001), 0, 0);
         check_outs(0);
      end
      bus(1'b1, 8'h40, 32'h0000_7777);
      rd_chk(8'h40, taper_m(longint'($signed(dia_s))));
      $display("taper test done");
      wr_reg(8'h00, 2);
      wr_reg(8'h08, 0);
      wr_reg(8'h0C, 0);
      wr_reg(8'h04, 2000);
      wr_reg(8'h14, -50);
      wr_reg(8'h18, 700);
      wr_reg(8'h1C, 500);
      wr_reg(8'h20, 300);
      wr_reg(8'h24, 1000);
      for (int i = 0; i < 5; i++) begin
         setin(6000, ws[i], rs[i]);
         check_outs(0);
      end
      $display("friction test done");
      wr_reg(8'h10, 2000);
      wr_reg(8'h28, 800);
      wr_reg(8'h2C, 1500);
      for (int k = 0; k < 4; k++) begin
         setin(k[0] ? S : 2000, 0, 0);
         wr_reg(8'h30, k[1] ? 20000 : 10000);
         wr_reg(8'h38, k[0] ? -5000 : 5000);
         wr_reg(8'h00, k == 3 ? 0 : 2);
         check_outs(rv[14]);
         rd_chk(8'h50, iner_m(rv[14], k[0] ? S : 2000));
      end
      wr_reg(8'h34, 250);
      step_s <= 16'h000A;
      check_outs(10 * UD * 250 / 100);
      step_s <= 16'h0000;
      check_outs(0);
      $display("inertia test done");
      close_out();
   end

   initial begin
      repeat (40000) @(posedge clk_sys);
      bad_count++;
      $display("[ERR] %0t watchdog expired", $time);
      close_out();
   end
endmodule // tb_winder_tension_torque_comp
